// File: design/csac_top.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
// Functional notes
// - Select zero decodes every address as boot select until validated.
// - Wait count cycles are inserted before the internal acknowledge.
// - Auto acknowledge bit zero means no internal acknowledge at all.
// - Burst read off splits wide reads into port-width beats.
// - Burst write off splits wide writes into port-width beats.
// - Port width 01 is byte, 10 and 11 are halfword, 00 reserved.
// - Halfword ports use data lanes 31 to 16 only.
// - The lowest address bit is never driven externally.
// - Select one stays quiet until valid; reset clears every valid bit.
// - Select zero control resets to known values; select one does not.
// - Outside boot, writes to a protected range that no other select covers assert no select and end as unmapped.
module csac_top
    import csac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire csac_req_s req,
    input wire logic req_valid,
    output logic req_done,
    output logic [31:0] req_rdata,
    output logic req_unmapped,
    output logic [1:0] select_n,
    output logic [31:1] ext_addr,
    output logic ext_write,
    output logic burst,
    output logic [31:0] ext_dout,
    output logic ext_doe_n,
    input wire logic [31:0] ext_din,
    input wire logic transfer_ack_n
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0] base [2];
    logic [31:0] mask [2];
    logic [15:0] ctrl [2];
    logic [31:0] rdata_mux;
    logic ack_sync1;
    logic ack_sync2;

    // Only the upper sixteen address bits take part in a match; the mask
    // decides which of them must agree with the base.
    function automatic logic hit(input logic [31:0] a, input logic [31:0] b,
                                 input logic [31:0] m);
        hit = ((a[31:16] ^ b[31:16]) & ~m[31:16]) == 16'h0000;
    endfunction : hit

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl[0] <= CTRL0_RESET;
        end else if (reg_wr && reg_addr == OFS_SEL0_CTRL) begin
            ctrl[0] <= reg_wdata[15:0] & CTRL_WMASK;
        end
    end

    // Select one control and both bases have no reset value. Software must
    // program them before setting a valid bit; until then the decode
    // ignores them, so their unknown contents never reach the pins.
    always_ff @(posedge sys_clk) begin
        if (reg_wr && reg_addr == OFS_SEL1_CTRL) begin
            ctrl[1] <= reg_wdata[15:0] & CTRL_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reg_wr && reg_addr == OFS_SEL0_BASE) begin
            base[0] <= {reg_wdata[31:16], 16'h0000};
        end
        if (reg_wr && reg_addr == OFS_SEL1_BASE) begin
            base[1] <= {reg_wdata[31:16], 16'h0000};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mask[0] <= 32'h0;
            mask[1] <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == OFS_SEL0_MASK) begin
                mask[0] <= reg_wdata & MASK_WMASK;
            end
            if (reg_wr && reg_addr == OFS_SEL1_MASK) begin
                mask[1] <= reg_wdata & MASK_WMASK;
            end
        end
    end

    // ************************************************************
    // Transfer engine
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACK} csac_st_e;
    csac_st_e state;
    logic sel;
    logic [3:0] wait_cnt;
    logic [1:0] beats_left;
    logic [31:0] rd_acc;
    logic [31:0] cur_addr;
    logic [31:0] wdata_q;
    logic cur_write;
    logic [1:0] step;
    logic hit0;
    logic hit1;
    logic boot;
    logic use_sel;
    logic any_hit;
    logic [15:0] c;
    logic byte_port;
    logic [1:0] beats;
    logic take;
    logic miss;
    logic wait_done;
    logic beat_ack;
    logic last_beat;

    // ************************************************************
    // Address decode
    // ************************************************************
    // Select zero answers every address until its valid bit is set, so a
    // boot memory can be reached before any register has been written.
    assign boot = !mask[0][VALID_BIT];
    assign hit0 = boot || (hit(req.addr, base[0], mask[0]) &&
                  !(req.write && mask[0][WP_BIT]));
    assign hit1 = mask[1][VALID_BIT] && hit(req.addr, base[1], mask[1]) &&
                  !(req.write && mask[1][WP_BIT]);
    assign use_sel = hit0 ? 1'b0 : 1'b1;
    assign any_hit = hit0 || hit1;
    assign c = ctrl[use_sel];
    assign byte_port = c[PORT_LSB+:2] == PORT_BYTE;

    // Beats counts the beats that follow the first one, so a single beat
    // transfer needs no extra state.
    always_comb begin
        beats = 2'd0;
        if (req.size == CSAC_LONG) begin
            beats = byte_port ? 2'd3 : 2'd1;
        end else if (req.size == CSAC_HALF && byte_port) begin
            beats = 2'd1;
        end
    end

    // A byte port fills the word one byte at a time, a halfword port one
    // half at a time; the first beat ends up in the most significant part.
    function automatic logic [31:0] lane_shift(input logic [31:0] acc,
                                               input logic [31:0] din,
                                               input logic [1:0] width);
        lane_shift = width == 2'd1 ? {acc[23:0], din[31:24]}
                                   : {acc[15:0], din[31:16]};
    endfunction : lane_shift

    // The sequencing, handshake and data path processes below key off these terms, so that the state
    // machine and the data path cannot disagree about where a beat ends.
    assign take = state == ST_IDLE && req_valid && any_hit;
    assign miss = state == ST_IDLE && req_valid && !any_hit;
    assign wait_done = ctrl[sel][AUTO_ACK_BIT]
                       ? wait_cnt == ctrl[sel][WAIT_LSB+:4]
                       : !ack_sync2;
    assign beat_ack = state == ST_ACK;
    assign last_beat = beats_left == 2'd0;

    // ************************************************************
    // Acknowledge synchroniser
    // ************************************************************
    // The far side drives its acknowledge on its own timing, so it passes
    // two flops before the state machine looks at it; this costs two
    // cycles on every externally ended beat.
    always_ff @(posedge sys_clk) begin
        ack_sync1 <= transfer_ack_n;
        ack_sync2 <= ack_sync1;
    end

    // ************************************************************
    // Beat sequencing
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (take) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (wait_done) begin
                        state <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    state <= last_beat ? ST_IDLE : ST_WAIT;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // The count saturates, so a long external wait can never wrap it round
    // into a match that would end a later beat early.
    // wait count
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wait_cnt <= 4'h0;
        end else if (take || beat_ack) begin
            wait_cnt <= 4'h0;
        end else if (state == ST_WAIT && wait_cnt != 4'hf) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            select_n <= 2'b11;
            burst <= 1'b0;
            sel <= 1'b0;
        end else if (take) begin
            select_n <= hit0 ? 2'b10 : 2'b01;
            sel <= use_sel;
            burst <= beats != 2'd0 &&
                     (req.write ? c[BURST_WR_BIT] : c[BURST_RD_BIT]);
        end else if (beat_ack && last_beat) begin
            select_n <= 2'b11;
            burst <= 1'b0;
        end
    end

    // ************************************************************
    // Handshake outputs
    // ************************************************************
    // unmapped answer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_done <= 1'b0;
            req_unmapped <= 1'b0;
        end else begin
            req_done <= miss || (beat_ack && last_beat);
            req_unmapped <= miss;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            beats_left <= 2'd0;
            cur_addr <= 32'h0;
            cur_write <= 1'b0;
            step <= 2'd1;
        end else if (take) begin
            beats_left <= beats;
            cur_addr <= req.addr;
            cur_write <= req.write;
            step <= byte_port ? 2'd1 : 2'd2;
        end else if (beat_ack && !last_beat) begin
            beats_left <= beats_left - 2'd1;
            cur_addr <= cur_addr + {30'h0, step};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wdata_q <= 32'h0;
            rd_acc <= 32'h0;
            req_rdata <= 32'h0;
        end else if (take) begin
            wdata_q <= req.wdata;
            rd_acc <= 32'h0;
        end else if (beat_ack) begin
            rd_acc <= lane_shift(rd_acc, ext_din, step);
            if (last_beat) begin
                req_rdata <= lane_shift(rd_acc, ext_din, step);
            end else begin
                wdata_q <= step == 2'd1 ? {wdata_q[23:0], 8'h00}
                                        : {wdata_q[15:0], 16'h0000};
            end
        end
    end

    // ************************************************************
    // External pins
    // ************************************************************
    // no lowest bit
    assign ext_addr = cur_addr[31:1];
    assign ext_write = cur_write && state != ST_IDLE;
    // The lanes are driven only while a write is in progress, so a read
    // never fights the far side for the data bus.
    assign ext_doe_n = !(cur_write && state != ST_IDLE);
    always_comb begin
        if (step == 2'd1) begin
            ext_dout = {wdata_q[31:24], 24'h0};
        end else begin
            ext_dout = {wdata_q[31:16], 16'h0000};
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    // The status word shows the boot mode, a busy flag and the select in
    // use, so software can see when select zero has left boot decoding.
    always_comb begin
        unique case (reg_addr)
            OFS_SEL0_BASE: rdata_mux = base[0];
            OFS_SEL0_MASK: rdata_mux = mask[0];
            OFS_SEL0_CTRL: rdata_mux = {16'h0, ctrl[0]};
            OFS_SEL1_BASE: rdata_mux = base[1];
            OFS_SEL1_MASK: rdata_mux = mask[1];
            OFS_SEL1_CTRL: rdata_mux = {16'h0, ctrl[1]};
            OFS_STATUS: rdata_mux = {29'h0, boot, state != ST_IDLE, sel};
            default: rdata_mux = 32'h0;
        endcase
    end

    // Read data falls back to zero outside the answer cycle, so a stale
    // value can never be mistaken for a fresh read.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_mux;
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule : csac_top

// File: design/csac_pkg.sv
package csac_pkg;
    localparam logic [11:0] OFS_SEL0_BASE = 12'h080;
    localparam logic [11:0] OFS_SEL0_MASK = 12'h084;
    localparam logic [11:0] OFS_SEL0_CTRL = 12'h088;
    localparam logic [11:0] OFS_SEL1_BASE = 12'h08c;
    localparam logic [11:0] OFS_SEL1_MASK = 12'h090;
    localparam logic [11:0] OFS_SEL1_CTRL = 12'h094;
    localparam logic [11:0] OFS_STATUS = 12'h098;
    // Control register field positions.
    localparam int WAIT_LSB = 10;
    localparam int AUTO_ACK_BIT = 8;
    localparam int PORT_LSB = 6;
    localparam int BEM_BIT = 5;
    localparam int BURST_RD_BIT = 4;
    localparam int BURST_WR_BIT = 3;
    // Mask register field positions.
    localparam int WP_BIT = 8;
    localparam int VALID_BIT = 0;
    localparam logic [15:0] CTRL_WMASK = 16'h3df8;
    localparam logic [31:0] MASK_WMASK = 32'hffff_01ff;
    localparam logic [15:0] CTRL0_RESET = 16'h3da0;
    localparam logic [1:0] PORT_RESERVED = 2'h0;
    localparam logic [1:0] PORT_BYTE = 2'h1;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [1:0] size;
        logic [31:0] wdata;
    } csac_req_s;

    typedef enum logic [1:0] {
        CSAC_BYTE,
        CSAC_HALF,
        CSAC_LONG
    } csac_size_e;
endpackage : csac_pkg

// File: dv/csac_properties.sv
`timescale 1ns/100ps
module csac_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic req_valid,
    input wire logic req_done,
    input wire logic req_unmapped,
    input wire logic [1:0] select_n,
    input wire logic ext_write,
    input wire logic ext_doe_n
);
    // ****************
    // Port relations
    // ****************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence s_idle_req;
        req_valid && select_n == 2'h3 && !req_done;
    endsequence
    sequence s_began;
        select_n != 2'h3 || (req_done && req_unmapped);
    endsequence
    property p_start;
        s_idle_req |=> s_began;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_rel_quiet;
        $fell(rst) |-> select_n == 2'h3 && !req_done;
    endproperty
    a_rel_quiet: assert property (p_rel_quiet) else $error("busy");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata");
    property p_done_pulse;
        req_done |=> !req_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("dn");
    property p_unmapped;
        req_unmapped |-> req_done && select_n == 2'h3;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("miss");
    property p_one_sel;
        select_n != 2'h0;
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("two sel");
    property p_doe;
        !ext_doe_n |-> ext_write && select_n != 2'h3;
    endproperty
    a_doe: assert property (p_doe) else $error("drive on read");
    property p_sel_done;
        req_done |=> select_n == 2'h3;
    endproperty
    a_sel_done: assert property (p_sel_done) else $error("sel");
endmodule : csac_properties
bind csac_top csac_properties i_csac_properties (.sys_clk, .rst, .reg_rd,
    .reg_rdata, .req_valid, .req_done, .req_unmapped, .select_n,
    .ext_write, .ext_doe_n);

// File: dv/csac_mem_model.sv
`timescale 1ns/100ps
module csac_mem_model (
    input wire logic sys_clk,
    input wire logic clr,
    input wire logic [1:0] select_n,
    input wire logic [31:1] ext_addr,
    input wire logic ext_write,
    input wire logic burst,
    input wire logic [31:0] ext_dout,
    input wire logic ext_doe_n,
    input wire logic ack_on,
    output logic [31:0] ext_din,
    output logic transfer_ack_n = 1'b1
);
    // ****************
    // Far side memory
    // ****************
    logic [1:0] seen = 2'h0;
    logic bseen = 1'b0, acked = 1'b0, was = 1'b0, got = 1'b0;
    logic [31:1] pa = '0;
    logic [31:0] wlog = 32'h0;
    logic [15:0] fr = 16'h0;
    logic [3:0] cyc = 4'h0;
    wire sel = select_n != 2'h3;
    wire nb = sel && (!was || ext_addr != pa);
    wire cap = !ext_doe_n && (nb || !got);
    // answer on upper lanes; idle lanes keep changing.
    assign ext_din = (sel && !ext_write) ? {ext_addr[16:1], fr} : {fr, ~fr};
    always @(posedge sys_clk) begin
        fr <= fr + 16'h1;
        was <= sel;
        pa <= ext_addr;
        got <= (got && !nb) || cap;
        cyc <= nb ? 4'h0 : cyc + {3'h0, cyc != 4'hf};
        if (ack_on && sel && !acked && !nb && cyc >= 4'h3) begin
            transfer_ack_n <= 1'b0;
            acked <= 1'b1;
        end else begin
            transfer_ack_n <= 1'b1;
            if (nb) acked <= 1'b0;
        end
        seen <= clr ? 2'h0 : seen | ~select_n;
        bseen <= clr ? 1'b0 : bseen | (sel & burst);
        if (clr) wlog <= 32'h0;
        else if (cap) wlog <= {wlog[15:0], ext_dout[31:16]};
    end
endmodule : csac_mem_model

// File: dv/testbench.sv
`timescale 1ns/100ps
module testbench import csac_pkg::*;;
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, req_valid = 0;
    logic clr = 0, ack_on = 0, dn, unm;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, req_rdata, ext_dout, ext_din;
    csac_req_s req = '0;
    logic req_done, req_unmapped, ext_write, burst, ext_doe_n;
    logic transfer_ack_n;
    logic [1:0] select_n, p;
    logic [31:1] ext_addr;
    logic [31:0] rdat;
    int errors = 0, num_checks = 0, lat, tick = 0, lw, lh;
    csac_top i_csac_top (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .req, .req_valid, .req_done, .req_rdata,
        .req_unmapped, .select_n, .ext_addr, .ext_write, .burst, .ext_dout,
        .ext_doe_n, .ext_din, .transfer_ack_n);
    csac_mem_model i_csac_mem_model (.sys_clk, .clr, .select_n, .ext_addr,
        .ext_write, .burst, .ext_dout, .ext_doe_n, .ack_on, .ext_din,
        .transfer_ack_n);
    wire [31:0] seen = {30'h0, i_csac_mem_model.seen};
    wire [31:0] bseen = {31'h0, i_csac_mem_model.bseen};
    // ****************
    // Tasks
    // ****************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata & m, e);
        @(posedge sys_clk);
    endtask : rd
    task automatic go(input logic [31:0] a, input logic w,
                      input logic [1:0] s, input logic [31:0] d);
        clr <= 1'b1;
        req <= '{a, w, s, d};
        req_valid <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        req_valid <= 1'b0;
    endtask : go
    task automatic wt(input int n);
        lat = 0;
        do begin
            @(negedge sys_clk);
            lat++;
        end while (req_done !== 1'b1 && lat < n);
        {dn, unm, rdat} = {req_done, req_unmapped, req_rdata};
        @(posedge sys_clk);
    endtask : wt
    task automatic xf(input logic [31:0] a, input logic w,
                      input logic [1:0] s, input logic [31:0] d);
        go(a, w, s, d);
        wt(300);
    endtask : xf
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        tick++;
        if (tick == 6000) begin
            errors++;
            give_verdict();
        end
    end
    // ****************
    // Tests
    // ****************
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(OFS_SEL0_CTRL, 32'hffff, {16'h0, CTRL0_RESET});
        rd(OFS_SEL0_MASK, 32'h1, 32'h0);
        rd(OFS_STATUS, 32'h4, 32'h4);
        wr(OFS_SEL1_CTRL, 32'hffff);
        rd(OFS_SEL1_CTRL, 32'hffff, {16'h0, CTRL_WMASK});
        rd(12'h0fc, 32'hffff_ffff, 32'h0);
        $display("register test done");
        xf(32'h0400_0100, 1'b0, 2'h2, 32'h0);
        chk(rdat, 32'h0080_0081);
        chk(seen, 32'h1);
        chk(bseen, 32'h0);
        xf(32'h0400_0100, 1'b0, 2'h1, 32'h0);
        lw = lat;
        wr(OFS_SEL0_CTRL, 32'h0980);
        xf(32'h0400_0100, 1'b0, 2'h1, 32'h0);
        chk(32'(lw - lat), 32'd13);
        lw = lat;
        for (int i = 0; i < 4; i++) begin
            p = 2'(i + 2);
            wr(OFS_SEL0_CTRL, {16'h0, 2'h0, 4'h2, 2'h1, p, 6'h0});
            xf(32'h0400_0100, 1'b0, 2'h2, 32'h0);
            if (i == 0) lh = lat;
            chk(32'(lat), 32'(p == 2'h1 ? 3 * lh - 2 * lw : lh));
        end
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SEL0_CTRL, 32'h0980 | (32'(i) << 3));
            xf(32'h0400_0100, 1'b0, 2'h2, 32'h0);
            chk(bseen, 32'(i[1]));
            xf(32'h0400_0100, 1'b1, 2'h2, 32'h1234_5678);
            chk(bseen, 32'(i[0]));
            chk(i_csac_mem_model.wlog, 32'h1234_5678);
        end
        $display("width and burst test done");
        wr(OFS_SEL0_CTRL, 32'h0080);
        ack_on <= 1'b1;
        xf(32'h0400_0100, 1'b0, 2'h1, 32'h0);
        chk({31'h0, dn}, 32'h1);
        ack_on <= 1'b0;
        go(32'h0400_0100, 1'b0, 2'h1, 32'h0);
        wt(60);
        chk({31'h0, dn}, 32'h0);
        ack_on <= 1'b1;
        wt(40);
        chk({31'h0, dn}, 32'h1);
        ack_on <= 1'b0;
        $display("acknowledge test done");
        wr(OFS_SEL0_CTRL, 32'h0980);
        wr(OFS_SEL1_BASE, 32'h0010_0000);
        wr(OFS_SEL1_CTRL, 32'h0980);
        wr(OFS_SEL1_MASK, 32'h000f_0101);
        wr(OFS_SEL0_BASE, 32'h0080_0000);
        wr(OFS_SEL0_MASK, 32'h001f_0001);
        rd(OFS_STATUS, 32'h4, 32'h0);
        xf(32'h0010_0040, 1'b0, 2'h1, 32'h0);
        chk(seen, 32'h2);
        xf(32'h0010_0040, 1'b1, 2'h1, 32'h0);
        chk(seen, 32'h0);
        xf(32'h0400_0000, 1'b0, 2'h1, 32'h0);
        chk({31'h0, unm}, 32'h1);
        $display("decode test done");
        give_verdict();
    end
endmodule : testbench
